// File: core/vscc_sync_clock_control.sv
// Module: sync edge, clamp, coast, pixel clock and sync output control with 2-wire register port
`timescale 1ns/100ps
// What this block does
// - Horizontal timing comes only from the hsync leading edge; trailing edge only starts the internal clamp count.
// - Bit 7 of the sync polarity register picks falling (0) or rising (1) edge.
// - External clamp pin used only when enable bit is 1; bit resets to 0.
// - Clamp pin disabled: clamp counted as delay then duration from hsync trailing edge.
// - Clamp pin active level follows the clamp polarity bit.
// - Active coast stops hsync tracking; clock keeps present frequency and phase.
// - Coast pin active level follows coast polarity, which resets to 1.
// - An internally generated coast is offered so the coast pin is optional.
// - External clock select 1 makes the external pin the pixel clock.
// - With external clock, all other functions including phase adjust keep working.
// - Sampling clock invert pin inverts sampling clock, shifting phase by 180 degrees.
// - Alternate pixel sampling: odd then even pixels, inversion toggled between frames.
// - Reconstructed hsync output aligned with data, polarity and width from registers.
// - Composite sync output selects slicer result or delayed raw hsync.
// - Slicer output is noninverting digital sync from embedded sync input.
// - All configuration bits are written and read over the 2-wire serial port.
module vscc_sync_clock_control (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [1:0] addrSelect,
	input  wire logic       scl,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	input  wire logic       hsyncIn,
	input  wire logic       clampIn,
	input  wire logic       coastIn,
	input  wire logic       pllClockIn,
	input  wire logic       extPixelClockIn,
	input  wire logic       samplingClockInvertIn,
	input  wire logic       embeddedSyncInput,
	output logic            pllRefPulse,
	output logic            pllCoast,
	output logic            clampActive,
	output logic            pixelClockOut,
	output logic            samplingClockOut,
	output logic            hsyncReconstructedOut,
	output logic            syncSlicerOutput
);
	import vscc_pkg::*;

	// ==========================================================================
	// Serial port state
	vscc_i2c_e   state, next_state;
	vscc_kind_e  byteKind, next_byteKind;
	logic [3:0]  bitCnt, next_bitCnt;
	logic [7:0]  shift, next_shift;
	logic [7:0]  ptr, next_ptr;
	logic        rnw, next_rnw;
	logic        masterAck, next_masterAck;
	logic        sclPrev, sdaPrev;
	vscc_cfg_s   cfg, next_cfg;
	logic [7:0]  status;
	logic        sclRise, sclFall, i2cStart, i2cStop;

	// Bus edges; inputs are already in the clk domain
	assign sclRise  = scl & ~sclPrev;
	assign sclFall  = ~scl & sclPrev;
	assign i2cStart = scl & sclPrev & sdaPrev & ~sdaIn;
	assign i2cStop  = scl & sclPrev & ~sdaPrev & sdaIn;

	// Open drain: only ever pull low, during acks and zero data bits
	assign sdaOut = 1'b0;
	assign sdaOe  = (state == S_ACK) | ((state == S_SEND) & ~shift[7]);

	// Register read decode, used for the first and every following read byte
	function automatic logic [7:0] regRead(input vscc_cfg_s c, input logic [7:0] a,
			input logic [7:0] st);
		case (a)
			REG_SYNC_POL:  regRead = c.syncPol;
			REG_CTRL:      regRead = c.ctrl;
			REG_CLAMP_DLY: regRead = c.clampDelay;
			REG_CLAMP_DUR: regRead = c.clampDur;
			REG_HS_WIDTH:  regRead = c.hsRecWidth;
			REG_COAST_TO:  regRead = c.coastTimeout;
			REG_STATUS:    regRead = st;
			default:       regRead = 8'h00;
		endcase
	endfunction

	// Next state of the serial slave and the configuration it writes
	always_comb begin
		next_state     = state;
		next_byteKind  = byteKind;
		next_bitCnt    = bitCnt;
		next_shift     = shift;
		next_ptr       = ptr;
		next_rnw       = rnw;
		next_masterAck = masterAck;
		next_cfg       = cfg;
		if (i2cStop) begin
			next_state = S_IDLE;
		end else if (i2cStart) begin
			// Repeated start keeps the pointer, so write-pointer-then-read works
			next_state    = S_RECV;
			next_bitCnt   = 4'h0;
			next_byteKind = KIND_ADDR;
		end else begin
			case (state)
				S_RECV: begin
					if (sclRise && bitCnt < BITS_PER_BYTE) begin
						next_shift  = {shift[6:0], sdaIn};
						next_bitCnt = bitCnt + 4'h1;
					end else if (sclFall && bitCnt == BITS_PER_BYTE) begin
						next_state = S_ACK;
						case (byteKind)
							KIND_ADDR: begin
								next_rnw = shift[0];
								if (shift[7:1] != {DEV_ADDR_BASE, addrSelect}) begin
									next_state = S_IDLE;
								end
							end
							KIND_PTR: begin
								next_ptr = shift;
							end
							default: begin
								// Writes land in the live configuration at once
								case (ptr)
									REG_SYNC_POL:  next_cfg.syncPol      = shift;
									REG_CTRL:      next_cfg.ctrl         = shift;
									REG_CLAMP_DLY: next_cfg.clampDelay   = shift;
									REG_CLAMP_DUR: next_cfg.clampDur     = shift;
									REG_HS_WIDTH:  next_cfg.hsRecWidth   = shift;
									REG_COAST_TO:  next_cfg.coastTimeout = shift;
									default:       next_cfg              = cfg;
								endcase
								next_ptr = ptr + 8'h01;
							end
						endcase
					end
				end
				S_ACK: begin
					if (sclFall) begin
						next_bitCnt = 4'h0;
						if (rnw && byteKind == KIND_ADDR) begin
							next_state = S_SEND;
							next_shift = regRead(cfg, ptr, status);
							next_ptr   = ptr + 8'h01;
						end else begin
							next_state    = S_RECV;
							next_byteKind = (byteKind == KIND_ADDR) ? KIND_PTR : KIND_DATA;
						end
					end
				end
				S_SEND: begin
					if (sclRise && bitCnt < BITS_PER_BYTE) begin
						next_bitCnt = bitCnt + 4'h1;
					end else if (sclFall && bitCnt == BITS_PER_BYTE) begin
						next_state = S_MACK;
					end else if (sclFall && bitCnt != 4'h0) begin
						next_shift = {shift[6:0], 1'b0};
					end
				end
				S_MACK: begin
					if (sclRise) begin
						next_masterAck = ~sdaIn;
					end else if (sclFall) begin
						next_bitCnt = 4'h0;
						next_state  = masterAck ? S_SEND : S_IDLE;
						next_shift  = regRead(cfg, ptr, status);
						next_ptr    = masterAck ? ptr + 8'h01 : ptr;
					end
				end
				default: begin
					next_state = S_IDLE;
				end
			endcase
		end
	end

	// Serial slave and configuration registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state     <= S_IDLE;
			byteKind  <= KIND_ADDR;
			bitCnt    <= 4'h0;
			shift     <= 8'h00;
			ptr       <= 8'h00;
			rnw       <= 1'b0;
			masterAck <= 1'b0;
			sclPrev   <= 1'b1;
			sdaPrev   <= 1'b1;
			cfg       <= {RST_SYNC_POL, RST_CTRL, RST_CLAMP_DLY, RST_CLAMP_DUR,
				RST_HS_WIDTH, RST_COAST_TO};
		end else begin
			state     <= next_state;
			byteKind  <= next_byteKind;
			bitCnt    <= next_bitCnt;
			shift     <= next_shift;
			ptr       <= next_ptr;
			rnw       <= next_rnw;
			masterAck <= next_masterAck;
			sclPrev   <= scl;
			sdaPrev   <= sdaIn;
			cfg       <= next_cfg;
		end
	end

	// ==========================================================================
	// Sync, clamp and coast
	vscc_clamp_e clampPhase, next_clampPhase;
	logic [7:0]  clampCnt, next_clampCnt;
	logic [7:0]  missCnt, next_missCnt;
	logic [7:0]  hsCnt, next_hsCnt;
	logic [2:0]  hsDelay, next_hsDelay;
	logic        hsyncPrev, hsyncNorm, lead, trail;
	logic        next_pllRefPulse, next_pllCoast, next_clampActive;
	logic        next_hsyncOut, next_slicerOut, extCoast, intCoast;

	// Normalise hsync so the chosen leading edge is always a rise
	assign hsyncNorm = cfg.syncPol[BIT_HSYNC_POL] ? hsyncIn : ~hsyncIn;
	assign lead      = hsyncNorm & ~hsyncPrev;
	assign trail     = ~hsyncNorm & hsyncPrev;
	assign extCoast  = coastIn == cfg.syncPol[BIT_COAST_POL];
	assign intCoast  = cfg.ctrl[BIT_INT_COAST] & (missCnt >= cfg.coastTimeout);
	assign status    = {4'h0, samplingClockInvertIn, hsyncNorm, pllCoast, clampActive};

	// Clock selection is a plain mux; the phase adjust downstream is shared by both sources
	assign pixelClockOut    = cfg.ctrl[BIT_EXT_CLK] ? extPixelClockIn : pllClockIn;
	assign samplingClockOut = pixelClockOut ^ samplingClockInvertIn;

	// Next values of the video-side timing
	always_comb begin
		next_clampPhase = clampPhase;
		next_clampCnt   = clampCnt;
		next_hsCnt      = hsCnt;
		next_missCnt    = (missCnt == 8'hff) ? missCnt : missCnt + 8'h01;
		if (lead) begin
			next_missCnt = 8'h00;
		end
		// Internal clamp runs from the trailing edge, which is useless for timing
		if (trail) begin
			next_clampPhase = C_DELAY;
			next_clampCnt   = cfg.clampDelay;
		end else begin
			case (clampPhase)
				C_DELAY: begin
					if (clampCnt != 8'h00) begin
						next_clampCnt = clampCnt - 8'h01;
					end else if (cfg.clampDur != 8'h00) begin
						next_clampPhase = C_ON;
						next_clampCnt   = cfg.clampDur;
					end else begin
						next_clampPhase = C_IDLE;
					end
				end
				C_ON: begin
					next_clampCnt   = clampCnt - 8'h01;
					next_clampPhase = (clampCnt == 8'h01) ? C_IDLE : C_ON;
				end
				default: begin
					next_clampPhase = C_IDLE;
				end
			endcase
		end
		if (lead) begin
			next_hsCnt = cfg.hsRecWidth;
		end else if (hsCnt != 8'h00) begin
			next_hsCnt = hsCnt - 8'h01;
		end
		next_pllCoast    = extCoast | intCoast;
		next_pllRefPulse = lead & ~next_pllCoast;
		next_clampActive = cfg.ctrl[BIT_EXT_CLAMP] ?
			(clampIn == cfg.syncPol[BIT_CLAMP_POL]) : (next_clampPhase == C_ON);
		next_hsyncOut    = ~((next_hsCnt != 8'h00) ^ cfg.syncPol[BIT_HSREC_POL]);
		next_hsDelay     = {hsDelay[1:0], hsyncIn};
		next_slicerOut   = cfg.ctrl[BIT_SLICER_SEL] ? hsDelay[2] : embeddedSyncInput;
	end

	// Video-side registers; every video-side output except the pixel and sampling clocks leaves from here
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clampPhase            <= C_IDLE;
			clampCnt              <= 8'h00;
			missCnt               <= 8'h00;
			hsCnt                 <= 8'h00;
			hsDelay               <= 3'h0;
			hsyncPrev             <= 1'b0;
			pllRefPulse           <= 1'b0;
			pllCoast              <= 1'b0;
			clampActive           <= 1'b0;
			hsyncReconstructedOut <= 1'b0;
			syncSlicerOutput      <= 1'b0;
		end else begin
			clampPhase            <= next_clampPhase;
			clampCnt              <= next_clampCnt;
			missCnt               <= next_missCnt;
			hsCnt                 <= next_hsCnt;
			hsDelay               <= next_hsDelay;
			hsyncPrev             <= hsyncNorm;
			pllRefPulse           <= next_pllRefPulse;
			pllCoast              <= next_pllCoast;
			clampActive           <= next_clampActive;
			hsyncReconstructedOut <= next_hsyncOut;
			syncSlicerOutput      <= next_slicerOut;
		end
	end

	// ==========================================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_leadOnly;
		pllRefPulse |-> $past(lead) && !$past(trail);
	endproperty
	a_leadOnly: assert property (p_leadOnly) else $error("ref pulse not from leading edge");

	property p_edgePolarity;
		$past(lead) && $stable(cfg.syncPol) |->
			$past(hsyncIn) == cfg.syncPol[BIT_HSYNC_POL];
	endproperty
	a_edgePolarity: assert property (p_edgePolarity) else $error("wrong hsync edge");

	property p_extClamp;
		$past(cfg.ctrl[BIT_EXT_CLAMP]) |->
			clampActive == ($past(clampIn) == $past(cfg.syncPol[BIT_CLAMP_POL]));
	endproperty
	a_extClamp: assert property (p_extClamp) else $error("clamp pin level misread");

	property p_intClampStart;
		trail && !cfg.ctrl[BIT_EXT_CLAMP] |=>
			clampPhase == C_DELAY && clampCnt == $past(cfg.clampDelay) && !clampActive;
	endproperty
	a_intClampStart: assert property (p_intClampStart) else $error("clamp delay not loaded");

	property p_intClampIgnorePin;
		!$past(cfg.ctrl[BIT_EXT_CLAMP]) |-> clampActive == (clampPhase == C_ON);
	endproperty
	a_intClampIgnorePin: assert property (p_intClampIgnorePin) else $error("clamp pin used");

	property p_coastBlocks;
		pllCoast |-> !pllRefPulse;
	endproperty
	a_coastBlocks: assert property (p_coastBlocks) else $error("tracking during coast");

	property p_coastPol;
		$past(!cfg.ctrl[BIT_INT_COAST]) |->
			pllCoast == ($past(coastIn) == $past(cfg.syncPol[BIT_COAST_POL]));
	endproperty
	a_coastPol: assert property (p_coastPol) else $error("coast polarity wrong");

	property p_intCoast;
		cfg.ctrl[BIT_INT_COAST] && missCnt >= cfg.coastTimeout |=> pllCoast;
	endproperty
	a_intCoast: assert property (p_intCoast) else $error("internal coast missing");

	property p_extClock;
		pixelClockOut == (cfg.ctrl[BIT_EXT_CLK] ? extPixelClockIn : pllClockIn);
	endproperty
	a_extClock: assert property (p_extClock) else $error("pixel clock source wrong");

	property p_hsRecStart;
		$past(lead) && $past(cfg.hsRecWidth) != 8'h00 && $stable(cfg.syncPol) |->
			hsyncReconstructedOut == cfg.syncPol[BIT_HSREC_POL];
	endproperty
	a_hsRecStart: assert property (p_hsRecStart) else $error("hsync out not started");

	property p_slicer;
		$past(cfg.ctrl[BIT_SLICER_SEL]) ? syncSlicerOutput == $past(hsyncIn, 4) :
			syncSlicerOutput == $past(embeddedSyncInput);
	endproperty
	a_slicer: assert property (p_slicer) else $error("composite sync source wrong");

	// Acknowledge must stand until the host's clock fall has been seen
	property p_ackDrive;
		state == S_ACK && !sclFall |=> state == S_ACK && sdaOe;
	endproperty
	a_ackDrive: assert property (p_ackDrive) else $error("ack not driven");

	c_intClamp: cover property (clampPhase == C_DELAY ##[1:300] clampActive);
	c_coast:    cover property (pllCoast ##1 !pllCoast);
	c_read:     cover property (state == S_SEND ##[1:1000] state == S_MACK);
	c_hsRec:    cover property (pllRefPulse ##1 hsCnt != 8'h00);

endmodule

// File: core/vscc_pkg.sv
// Package: register map, field positions, reset values and types of the sync and clock control
package vscc_pkg;

	// ==========================================================================
	// Serial port register offsets
	localparam logic [7:0] REG_SYNC_POL   = 8'h0f;
	localparam logic [7:0] REG_CTRL       = 8'h10;
	localparam logic [7:0] REG_CLAMP_DLY  = 8'h11;
	localparam logic [7:0] REG_CLAMP_DUR  = 8'h12;
	localparam logic [7:0] REG_HS_WIDTH   = 8'h13;
	localparam logic [7:0] REG_COAST_TO   = 8'h14;
	localparam logic [7:0] REG_STATUS     = 8'h15;

	// ==========================================================================
	// Field positions
	localparam int BIT_HSYNC_POL   = 7;
	localparam int BIT_COAST_POL   = 6;
	localparam int BIT_CLAMP_POL   = 5;
	localparam int BIT_HSREC_POL   = 4;
	localparam int BIT_EXT_CLAMP   = 0;
	localparam int BIT_EXT_CLK     = 1;
	localparam int BIT_INT_COAST   = 2;
	localparam int BIT_SLICER_SEL  = 3;

	// ==========================================================================
	// Reset values and serial address
	localparam logic [7:0] RST_SYNC_POL   = 8'h70;
	localparam logic [7:0] RST_CTRL       = 8'h00;
	localparam logic [7:0] RST_CLAMP_DLY  = 8'h04;
	localparam logic [7:0] RST_CLAMP_DUR  = 8'h08;
	localparam logic [7:0] RST_HS_WIDTH   = 8'h10;
	localparam logic [7:0] RST_COAST_TO   = 8'hc0;
	localparam logic [4:0] DEV_ADDR_BASE  = 5'h13;  // Arbitrary upper address bits
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

	// ==========================================================================
	// Types
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RECV = 3'b001,
		S_ACK  = 3'b010,
		S_SEND = 3'b011,
		S_MACK = 3'b100
	} vscc_i2c_e;

	typedef enum logic [1:0] {
		KIND_ADDR = 2'b00,
		KIND_PTR  = 2'b01,
		KIND_DATA = 2'b10
	} vscc_kind_e;

	typedef enum logic [1:0] {
		C_IDLE  = 2'b00,
		C_DELAY = 2'b01,
		C_ON    = 2'b10
	} vscc_clamp_e;

	typedef struct packed {
		logic [7:0] syncPol;
		logic [7:0] ctrl;
		logic [7:0] clampDelay;
		logic [7:0] clampDur;
		logic [7:0] hsRecWidth;
		logic [7:0] coastTimeout;
	} vscc_cfg_s;

endpackage

// File: verification/vscc_source_model.sv
// Graphics source model: line sync pulses, back porch clamp, coast pin and external clock
`timescale 1ns/100ps
module vscc_source_model (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       lineGo,
	input  wire logic [7:0] syncLen,
	input  wire logic       syncHigh,
	input  wire logic       clampUse,
	input  wire logic       clampHigh,
	input  wire logic       coastReq,
	input  wire logic       coastHigh,
	input  wire logic       extClkUse,
	output logic            hsyncIn,
	output logic            clampIn,
	output logic            coastIn,
	output logic            extPixelClockIn,
	output logic            embeddedSyncInput
);
	logic [7:0] syncCnt;
	logic [3:0] porchCnt;
	logic       inSync;

	// ==========================================================================
	// Line timing: sync tip, then a six cycle back porch at reference level
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			syncCnt         <= 8'h00;
			porchCnt        <= 4'h0;
			extPixelClockIn <= 1'b0;
		end else begin
			extPixelClockIn <= extClkUse & ~extPixelClockIn;
			if (lineGo) begin
				syncCnt <= syncLen;
			end else if (syncCnt != 8'h00) begin
				syncCnt  <= syncCnt - 8'h01;
				porchCnt <= (syncCnt == 8'h01) ? 4'h6 : 4'h0;
			end else if (porchCnt != 4'h0) begin
				porchCnt <= porchCnt - 4'h1;
			end
		end
	end

	// Pins; an unused clamp pin sits low so it can never clamp by accident
	assign inSync            = (syncCnt != 8'h00);
	assign hsyncIn           = syncHigh ? inSync : ~inSync;
	assign embeddedSyncInput = inSync;
	assign clampIn           = clampUse & ((porchCnt != 4'h0) ~^ clampHigh);
	assign coastIn           = coastReq ? coastHigh : ~coastHigh;
endmodule

// File: verification/test_video_adc_sync_clock_control.sv
// Testbench: serial registers, sync edge, clamp, coast, clock paths and sync outputs
`timescale 1ns/100ps
module test_video_adc_sync_clock_control;
	import vscc_pkg::*;

	localparam int         SYNC     = 16;    // Sync tip length in clocks
	localparam int         WIN      = 60;    // Cycles per observed line
	localparam logic [1:0] ADDR_SEL = 2'b10;

	logic       clk = 1'b0;
	logic       reset_n = 1'b0;
	logic       scl = 1'b1;
	logic       sdaHost = 1'b1;
	logic       pllClockIn = 1'b0;
	logic       samplingClockInvertIn = 1'b0;
	logic       lineGo = 1'b0;
	logic       syncHigh = 1'b0;
	logic       clampUse = 1'b0;
	logic       clampHigh = 1'b0;
	logic       coastReq = 1'b0;
	logic       coastHigh = 1'b1;
	logic       extClkUse = 1'b0;
	logic       win = 1'b0;
	logic       hsPol = 1'b1;
	logic       expPix;
	logic       sdaIn, sdaOe, hsyncIn, clampIn, coastIn, extPixelClockIn, embeddedSyncInput;
	logic       pllRefPulse, pllCoast, clampActive, pixelClockOut, samplingClockOut;
	logic       hsyncReconstructedOut, syncSlicerOutput, sdaOut;
	logic [7:0] refN, clampN, hsN, slN, refLat, regRd;
	logic [8:0] rxBits;
	int         cyc = 0;
	int         t0 = 0;
	int         failures = 0;
	int         checks = 0;
	logic [7:0] offs [6] = '{REG_SYNC_POL, REG_CTRL, REG_CLAMP_DLY, REG_CLAMP_DUR,
		REG_HS_WIDTH, REG_COAST_TO};
	logic [7:0] rsts [6] = '{RST_SYNC_POL, RST_CTRL, RST_CLAMP_DLY, RST_CLAMP_DUR,
		RST_HS_WIDTH, RST_COAST_TO};

	// Open-drain data line: while enabled the device puts its data value on the wire
	assign sdaIn = sdaHost & (~sdaOe | sdaOut);

	always #10 clk = ~clk;

	// PLL stand-in and cycle count
	always @(posedge clk) begin
		pllClockIn <= ~pllClockIn;
		cyc        <= cyc + 1;
	end

	// Per line tallies; cleared by the line start so they survive until read
	always @(posedge clk) begin
		if (lineGo) begin
			refN   <= 8'h00;
			clampN <= 8'h00;
			hsN    <= 8'h00;
			slN    <= 8'h00;
			refLat <= 8'h00;
		end else if (win) begin
			refN   <= refN + {7'h00, pllRefPulse};
			clampN <= clampN + {7'h00, clampActive};
			hsN    <= hsN + {7'h00, hsyncReconstructedOut === hsPol};
			slN    <= slN + {7'h00, syncSlicerOutput};
			if (pllRefPulse && refN == 8'h00)
				refLat <= 8'(cyc - t0);
		end
	end

	vscc_sync_clock_control dut_u (
		.clk                   (clk),
		.reset_n               (reset_n),
		.addrSelect            (ADDR_SEL),
		.scl                   (scl),
		.sdaIn                 (sdaIn),
		.sdaOut                (sdaOut),
		.sdaOe                 (sdaOe),
		.hsyncIn               (hsyncIn),
		.clampIn               (clampIn),
		.coastIn               (coastIn),
		.pllClockIn            (pllClockIn),
		.extPixelClockIn       (extPixelClockIn),
		.samplingClockInvertIn (samplingClockInvertIn),
		.embeddedSyncInput     (embeddedSyncInput),
		.pllRefPulse           (pllRefPulse),
		.pllCoast              (pllCoast),
		.clampActive           (clampActive),
		.pixelClockOut         (pixelClockOut),
		.samplingClockOut      (samplingClockOut),
		.hsyncReconstructedOut (hsyncReconstructedOut),
		.syncSlicerOutput      (syncSlicerOutput)
	);

	vscc_source_model model_u (
		.clk               (clk),
		.reset_n           (reset_n),
		.lineGo            (lineGo),
		.syncLen           (8'(SYNC)),
		.syncHigh          (syncHigh),
		.clampUse          (clampUse),
		.clampHigh         (clampHigh),
		.coastReq          (coastReq),
		.coastHigh         (coastHigh),
		.extClkUse         (extClkUse),
		.hsyncIn           (hsyncIn),
		.clampIn           (clampIn),
		.coastIn           (coastIn),
		.extPixelClockIn   (extPixelClockIn),
		.embeddedSyncInput (embeddedSyncInput)
	);

	// ==========================================================================
	// Helpers; serial phases last three clocks, above the two the port needs
	task automatic step();
		repeat (3) @(posedge clk);
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic endTest(input string name);
		$display("test %s done", name);
	endtask

	task automatic start();
		sdaHost <= 1'b1;
		step();
		scl <= 1'b1;
		step();
		sdaHost <= 1'b0;
		step();
		scl <= 1'b0;
		step();
	endtask

	task automatic stop();
		sdaHost <= 1'b0;
		step();
		scl <= 1'b1;
		step();
		sdaHost <= 1'b1;
		step();
	endtask

	// Nine bit slot: eight data bits then acknowledge, MSB first
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sdaHost <= tx[i];
			step();
			scl <= 1'b1;
			step();
			rx[i] = sdaIn;
			scl <= 1'b0;
			step();
		end
	endtask

	task automatic send(input logic [7:0] b);
		logic [8:0] rx;
		xfer({b, 1'b1}, rx);
		chk("ack", 8'h00, {7'h00, rx[0]});
	endtask

	task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
		start();
		send({DEV_ADDR_BASE, ADDR_SEL, 1'b0});
		send(a);
		send(d);
		stop();
	endtask

	// Pointer write, repeated start, one byte read closed by a not-acknowledge
	task automatic readReg(input logic [7:0] a, output logic [7:0] d);
		logic [8:0] rx;
		start();
		send({DEV_ADDR_BASE, ADDR_SEL, 1'b0});
		send(a);
		start();
		send({DEV_ADDR_BASE, ADDR_SEL, 1'b1});
		xfer(9'h1ff, rx);
		d = rx[8:1];
		stop();
	endtask

	task automatic runLine();
		lineGo <= 1'b1;
		win    <= 1'b1;
		t0 = cyc;
		@(posedge clk);
		lineGo <= 1'b0;
		repeat (WIN - 1) @(posedge clk);
		win <= 1'b0;
		@(posedge clk);
	endtask

	task automatic complete_run();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		complete_run();
	end

	// ==========================================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 6; i++) begin
			readReg(offs[i], regRd);
			chk("reset value", rsts[i], regRd);
			writeReg(offs[i], rsts[i] ^ 8'h5a);
			readReg(offs[i], regRd);
			chk("read back", rsts[i] ^ 8'h5a, regRd);
			writeReg(offs[i], rsts[i]);
		end
		readReg(8'h20, regRd);
		chk("unmapped", 8'h00, regRd);
		start();
		xfer({DEV_ADDR_BASE, ~ADDR_SEL, 1'b0, 1'b1}, rxBits);
		chk("foreign address", 8'h01, {7'h00, rxBits[0]});
		stop();
		endTest("registers");
		// Clamp pin driven while disabled must not shorten the counted clamp
		clampUse  <= 1'b1;
		clampHigh <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			syncHigh <= p[0];
			hsPol    <= p[0];
			writeReg(REG_SYNC_POL, {p[0], 2'b11, p[0], 4'h0});
			writeReg(REG_CTRL, RST_CTRL);
			runLine();
			chk("ref pulses", 8'h01, refN);
			chk("ref latency", 8'h01, {7'h00, refLat >= 8'h03 && refLat <= 8'h06});
			chk("hsync out width", RST_HS_WIDTH, hsN);
			chk("internal clamp", RST_CLAMP_DUR, clampN);
			chk("slicer", 8'(SYNC), slN);
			writeReg(REG_CTRL, 8'h08);
			runLine();
			chk("delayed hsync", p[0] ? 8'(SYNC) : 8'(WIN - 1 - SYNC), slN);
		end
		endTest("sync");
		writeReg(REG_CTRL, 8'h01);
		for (int c = 0; c < 2; c++) begin
			clampHigh <= c[0];
			writeReg(REG_SYNC_POL, {2'b11, c[0], 1'b1, 4'h0});
			runLine();
			chk("external clamp", 8'h06, clampN);
		end
		clampUse <= 1'b0;
		writeReg(REG_CTRL, RST_CTRL);
		endTest("clamp");
		for (int k = 0; k < 2; k++) begin
			coastHigh <= ~k[0];
			coastReq  <= 1'b1;
			writeReg(REG_SYNC_POL, {1'b1, ~k[0], 6'h30});
			runLine();
			chk("coasting", 8'h01, {7'h00, pllCoast});
			chk("ref while coasting", 8'h00, refN);
			coastReq <= 1'b0;
			step();
			runLine();
			chk("tracking", 8'h01, refN);
			chk("not coasting", 8'h00, {7'h00, pllCoast});
		end
		writeReg(REG_COAST_TO, 8'h10);
		writeReg(REG_CTRL, 8'h04);
		step();
		chk("internal coast", 8'h01, {7'h00, pllCoast});
		writeReg(REG_CTRL, RST_CTRL);
		step();
		chk("internal coast off", 8'h00, {7'h00, pllCoast});
		endTest("coast");
		// Invert pin moves only between lines, while the video is blanked
		for (int m = 0; m < 4; m++) begin
			extClkUse             <= m[1];
			samplingClockInvertIn <= m[0];
			writeReg(REG_CTRL, {6'h00, m[1], 1'b0});
			readReg(REG_STATUS, regRd);
			chk("status", {4'h0, m[0], 3'h0}, regRd);
			repeat (4) begin
				@(negedge clk);
				expPix = m[1] ? extPixelClockIn : pllClockIn;
				chk("pixel clock", {7'h00, expPix}, {7'h00, pixelClockOut});
				chk("sampling clock", {7'h00, expPix ^ m[0]}, {7'h00, samplingClockOut});
			end
			@(posedge clk);
		end
		endTest("clocks");
		complete_run();
	end
endmodule
